// ===== rtl/gpc_top.sv
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] Each pin has a direction bit: 1 output, 0 input.
// [R2] Direction of each pin reads back as currently applied.
// [R3] 24 pins, 0 to 23; pins 16 to 23 shared with analog inputs.
// [R4] After reset shared pins are analog until each gets a direction.
// [R5] A shared pin given a direction stays digital until reset.
// [R6] Drive-high sets the level high first, then makes it an output.
// [R7] Sample is 16 bits: conversion in top 10, bits 5 to 0 zero.
// [R8] Conversion starts on request and ends in under 6 us.
// [R9] Reduced variant: analog pins reset digital, go analog on sample.
// [R10] Reduced variant: six converter channels on fixed pins.
// [R11] Byte port: 8 data lines, line 0 read/write, line 1 select.
// [R12] Codes 0 to 3: bit 0 sets line 0, bit 1 strobe polarity.
// [R13] Code 4: all ten lines as plain block, no strobe.
// [R14] Strobe lasts 250 ns for writes, 550 ns for reads.
// [R15] Strobed transfers spaced 2.4 us for writes, 2 us for reads.
// [R16] After reset no byte-port line is driven.
// [R17] Writes drive data and line 0 before and through the strobe.
// [R18] Peripheral gives read data before the strobe ends.
module gpc_top #(
  parameter bit REDUCED = 1'b0 // Reduced board variant
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Sync reset, high
  input wire logic ce_i, // Clock enable
  input wire logic cyc_i, // Bus cycle
  input wire logic stb_i, // Bus strobe
  input wire logic we_i, // Bus write
  input wire logic [7:0] adr_i, // Byte address
  input wire logic [3:0] sel_i, // Byte lanes
  input wire logic [31:0] dat_i, // Write data
  output logic [31:0] dat_o, // Read data
  output logic ack_o, // Bus acknowledge
  input wire logic [23:0] gpio_i, // Pin levels
  output logic [23:0] gpio_o, // Pin output levels
  output logic [23:0] gpio_oe_o, // Pin drive enables
  output logic [23:0] pad_ana_o, // Pin in analog mode
  output logic adc_start_o, // Conversion start pulse
  output logic [2:0] adc_chan_o, // Converter channel
  input wire logic adc_done_i, // Conversion finished
  input wire logic [9:0] adc_data_i, // Conversion value
  input wire logic [7:0] bp_d_i, // Byte port data in
  output logic [7:0] bp_d_o, // Byte port data out
  output logic [7:0] bp_d_oe_o, // Byte port data enables
  input wire logic [1:0] bp_c_i, // Control lines in
  output logic [1:0] bp_c_o, // Control lines out
  output logic [1:0] bp_c_oe_o // Control line enables
);
  localparam int ADC_LIM = 299;

  typedef enum logic {
    AD_IDLE = 1'b0,
    AD_CONV = 1'b1
  } gpc_ad_e;

  logic ack_reg;
  logic [23:0] dir_reg;
  logic [23:0] dir_next;
  logic [23:0] out_reg;
  logic [23:0] out_next;
  logic [23:0] pend_reg;
  logic [7:0] ana_reg;
  logic [7:0] ana_next;
  logic [23:0] pin_ana;
  logic [23:0] ch_pin_m [gpc_pkg::NAD];
  logic [7:0] ch_ok;
  gpc_ad_e adc_st;
  logic [8:0] adc_cnt;
  logic [15:0] res_reg;
  logic bp_busy;
  logic [9:0] bp_rdata;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // One wait state: ack drops the cycle after it is given
  wire logic req = cyc_i && stb_i && !ack_reg;
  wire logic wr = req && we_i;
  wire logic [5:0] widx = adr_i[7:2];
  wire logic hit_dir = widx == gpc_pkg::OFS_DIR[7:2];
  wire logic hit_out = widx == gpc_pkg::OFS_OUT[7:2];
  wire logic hit_in = widx == gpc_pkg::OFS_IN[7:2];
  wire logic hit_cmd = widx == gpc_pkg::OFS_CMD[7:2];
  wire logic hit_ana = widx == gpc_pkg::OFS_ANA[7:2];
  wire logic hit_adc = widx == gpc_pkg::OFS_ADC[7:2];
  wire logic hit_res = widx == gpc_pkg::OFS_RES[7:2];
  wire logic hit_bcmd = widx == gpc_pkg::OFS_BCMD[7:2];
  wire logic hit_bdat = widx == gpc_pkg::OFS_BDAT[7:2];
  wire logic [23:0] lane_m =
    {{8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // ---------------------------------------------------------------
  // Pin commands
  // ---------------------------------------------------------------
  // Command word: pin in low bits, operation above
  wire logic dir_wr = wr && hit_dir;
  wire logic out_wr = wr && hit_out;
  wire logic [4:0] cmd_pin = dat_i[4:0];
  wire gpc_pkg::gpc_op_e cmd_op =
    gpc_pkg::gpc_op_e'(dat_i[gpc_pkg::CMD_OP_LSB +: 2]);
  wire logic cmd_ok = wr && hit_cmd && sel_i[0] && sel_i[1] &&
                      (cmd_pin < 5'(gpc_pkg::NPIN)); // R3
  wire logic [23:0] cmd_oh = cmd_ok ? (24'h000001 << cmd_pin) : 24'h0;
  wire logic cmd_lvl = cmd_op[1];
  wire logic cmd_drv = cmd_lvl; // High or low: level now, direction later
  // Pins that receive a direction this cycle
  wire logic [23:0] dir_apply =
    (dir_wr ? lane_m : 24'h0) | (cmd_drv ? 24'h0 : cmd_oh) | pend_reg;

  // Next direction and level
  always_comb begin
    dir_next = dir_reg;
    out_next = out_reg;
    if (dir_wr) dir_next = (dir_reg & ~lane_m) | (dat_i[23:0] & lane_m); // R1
    if (out_wr) out_next = (out_reg & ~lane_m) | (dat_i[23:0] & lane_m);
    if (!cmd_drv && cmd_op == gpc_pkg::OP_IN) dir_next = dir_next & ~cmd_oh;
    if (!cmd_drv && cmd_op == gpc_pkg::OP_OUT) dir_next = dir_next | cmd_oh;
    if (cmd_op == gpc_pkg::OP_HIGH) out_next = out_next | cmd_oh; // R6
    if (cmd_op == gpc_pkg::OP_LOW) out_next = out_next & ~cmd_oh;
    dir_next = dir_next | pend_reg; // R6
  end

  // Absent channels of the reduced variant are ignored
  wire logic adc_wr = wr && hit_adc && sel_i[0];
  wire logic [2:0] adc_ch = dat_i[2:0];
  wire logic adc_go = adc_wr && adc_st == AD_IDLE && ch_ok[adc_ch];

  // ---------------------------------------------------------------
  // Analog channel map
  // ---------------------------------------------------------------
  for (genvar c = 0; c < gpc_pkg::NAD; c++) begin : g_ch
    localparam int PIN = REDUCED ? int'(gpc_pkg::RED_PIN[5*c +: 5])
                                 : gpc_pkg::AD_BASE + c; // R3 R10
    localparam bit OK = REDUCED ? gpc_pkg::RED_OK[c] : 1'b1; // R10
    assign ch_ok[c] = OK;
    assign ch_pin_m[c] = OK ? (24'h000001 << PIN) : 24'h0;
    // Sampling sets in the reduced variant, a direction clears; set wins
    assign ana_next[c] = OK && ((ana_reg[c] &&
      !(|(ch_pin_m[c] & dir_apply))) ||
      (REDUCED && adc_go && adc_ch == 3'(c))); // R5 R9
  end

  // Pins currently handed to the converter
  always_comb begin
    pin_ana = 24'h0;
    for (int c = 0; c < gpc_pkg::NAD; c++) begin
      if (ana_reg[c]) pin_ana = pin_ana | ch_pin_m[c];
    end
  end

  // ---------------------------------------------------------------
  // Converter control
  // ---------------------------------------------------------------
  // Timeout keeps the conversion under its limit if done never comes
  wire logic adc_fin = adc_st == AD_CONV && (adc_done_i ||
    adc_cnt == 9'(gpc_pkg::ADC_MAX_CYC - 1)); // R8

  // Converter sequencer and result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adc_st <= AD_IDLE;
      adc_cnt <= 9'h000;
      adc_start_o <= 1'b0;
      adc_chan_o <= 3'h0;
      res_reg <= 16'h0000;
    end else if (ce_i) begin
      adc_start_o <= adc_go; // R8
      adc_cnt <= adc_cnt + 9'h001;
      unique case (adc_st)
        AD_IDLE: begin
          if (adc_go) begin
            adc_st <= AD_CONV;
            adc_cnt <= 9'h000;
            adc_chan_o <= adc_ch;
          end
        end
        AD_CONV: begin
          if (adc_fin) begin
            adc_st <= AD_IDLE;
            res_reg <= {adc_data_i, {gpc_pkg::RES_LSB{1'b0}}}; // R7
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin state registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_reg <= gpc_pkg::DIR_RST;
      out_reg <= gpc_pkg::OUT_RST;
      pend_reg <= 24'h0;
      ana_reg <= REDUCED ? gpc_pkg::ANA_RST_RED
                         : gpc_pkg::ANA_RST_FULL; // R4 R9
    end else if (ce_i) begin
      dir_reg <= dir_next;
      out_reg <= out_next;
      pend_reg <= cmd_drv ? cmd_oh : 24'h0;
      ana_reg <= ana_next;
    end
  end

  // Analog pins never drive
  assign gpio_o = out_reg;
  assign gpio_oe_o = dir_reg & ~pin_ana; // R1 R4
  assign pad_ana_o = pin_ana;

  // ---------------------------------------------------------------
  // Byte port
  // ---------------------------------------------------------------
  wire logic bcmd_wr = wr && hit_bcmd && (&sel_i[2:0]);
  wire gpc_pkg::gpc_bcmd_s bcmd = '{
    code: dat_i[gpc_pkg::BC_CODE_LSB +: 3],
    wr: dat_i[gpc_pkg::BC_WR_BIT],
    data: dat_i[9:0]
  };

  gpc_byte_port u_bp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .start_i(bcmd_wr),
    .cmd_i(bcmd),
    .busy_o(bp_busy),
    .rdata_o(bp_rdata),
    .d_i(bp_d_i),
    .d_o(bp_d_o),
    .d_oe_o(bp_d_oe_o),
    .c_i(bp_c_i),
    .c_o(bp_c_o),
    .c_oe_o(bp_c_oe_o)
  );

  // ---------------------------------------------------------------
  // Read mux and acknowledge
  // ---------------------------------------------------------------
  wire logic [31:0] rd_data =
    hit_dir ? {8'h00, dir_reg & ~pin_ana} : // R2
    hit_out ? {8'h00, out_reg} :
    hit_in ? {8'h00, gpio_i} :
    hit_ana ? {24'h000000, ana_reg} :
    hit_adc ? {31'h00000000, adc_st == AD_CONV} :
    hit_res ? {16'h0000, res_reg} :
    hit_bcmd ? {31'h00000000, bp_busy} :
    hit_bdat ? {22'h000000, bp_rdata} : 32'h00000000;

  // Unmapped reads return zero, writes are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_o <= 32'h00000000;
    end else if (ce_i) begin
      ack_reg <= req;
      if (req && !we_i) dat_o <= rd_data;
    end
  end
  assign ack_o = ack_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_dir_wr;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    dir_wr && sel_i[0] |=> dir_reg[7:0] == $past(dat_i[7:0]);
  endproperty
  a_dir_wr: assert property (p_dir_wr) // R1
    else $error("direction write lost");

  property p_dir_rd;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    req && !we_i && hit_dir |=>
      ack_o && dat_o[23:0] == $past(dir_reg & ~pin_ana);
  endproperty
  a_dir_rd: assert property (p_dir_rd) // R2
    else $error("direction readback wrong");

  property p_shared;
    @(posedge clk_i) disable iff (rst_i)
    !REDUCED |-> pin_ana[15:0] == 16'h0000;
  endproperty
  a_shared: assert property (p_shared) // R3
    else $error("unshared pin in analog mode");

  property p_ana_rst;
    @(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |->
      ana_reg == (REDUCED ? gpc_pkg::ANA_RST_RED : gpc_pkg::ANA_RST_FULL);
  endproperty
  a_ana_rst: assert property (p_ana_rst) // R4
    else $error("analog mode after reset wrong");

  property p_stay_dig;
    @(posedge clk_i) disable iff (rst_i)
    !REDUCED && !$past(rst_i) |-> (ana_reg & ~$past(ana_reg)) == 8'h00;
  endproperty
  a_stay_dig: assert property (p_stay_dig) // R5
    else $error("digital pin returned to analog");

  property p_high;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    cmd_ok && cmd_op == gpc_pkg::OP_HIGH |=>
      (out_reg & $past(cmd_oh)) != 24'h0 ##1
      (dir_reg & $past(cmd_oh, 2)) != 24'h0;
  endproperty
  a_high: assert property (p_high) // R6
    else $error("drive high order wrong");

  property p_res;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    adc_fin |=> res_reg == {$past(adc_data_i), 6'h00};
  endproperty
  a_res: assert property (p_res) // R7
    else $error("sample format wrong");

  property p_conv;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    adc_go |=> adc_st == AD_CONV ##[1:ADC_LIM] adc_st == AD_IDLE;
  endproperty
  a_conv: assert property (p_conv) // R8
    else $error("conversion too long");

  property p_red;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    REDUCED && adc_go |=> ana_reg[$past(adc_ch)];
  endproperty
  a_red: assert property (p_red) // R9
    else $error("sampled pin not analog");

  property p_red_ch;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    adc_wr && adc_st == AD_IDLE && !ch_ok[adc_ch] |=> adc_st == AD_IDLE;
  endproperty
  a_red_ch: assert property (p_red_ch) // R10
    else $error("absent channel converted");
endmodule : gpc_top
`default_nettype wire

// ===== common/gpc_pkg.sv
// ---------------------------------------------------------------
// Shared constants and types of the pin controller
// ---------------------------------------------------------------
package gpc_pkg;
  // Clock and pin counts
  localparam int CLK_NS = 20;
  localparam int NPIN = 24;
  localparam int NAD = 8;
  localparam int AD_BASE = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_DIR = 8'h00;
  localparam logic [7:0] OFS_OUT = 8'h04;
  localparam logic [7:0] OFS_IN = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_ANA = 8'h10;
  localparam logic [7:0] OFS_ADC = 8'h14;
  localparam logic [7:0] OFS_RES = 8'h18;
  localparam logic [7:0] OFS_BCMD = 8'h20;
  localparam logic [7:0] OFS_BDAT = 8'h24;

  // Values after reset
  localparam logic [23:0] DIR_RST = 24'h000000;
  localparam logic [23:0] OUT_RST = 24'h000000;
  localparam logic [7:0] ANA_RST_FULL = 8'hFF;
  localparam logic [7:0] ANA_RST_RED = 8'h00;

  // Field positions
  localparam int CMD_OP_LSB = 8;
  localparam int RES_LSB = 6;
  localparam int BC_CODE_LSB = 16;
  localparam int BC_WR_BIT = 20;
  localparam logic [2:0] CODE_BLOCK = 3'h4;

  // Reduced variant: channel to pin map, channel 7 in the top field
  localparam logic [39:0] RED_PIN =
    {5'h0C, 5'h0B, 5'h09, 5'h00, 5'h00, 5'h08, 5'h0A, 5'h07};
  localparam logic [7:0] RED_OK = 8'hE7;

  // Times in ns and their cycle counts
  localparam int WR_STB_NS = 250;
  localparam int RD_STB_NS = 550;
  localparam int WR_GAP_NS = 2400;
  localparam int RD_GAP_NS = 2000;
  localparam int ADC_MAX_NS = 6000;
  localparam int WR_STB_CYC = (WR_STB_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_STB_CYC = (RD_STB_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_GAP_CYC = (WR_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_GAP_CYC = (RD_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADC_MAX_CYC = (ADC_MAX_NS - 1) / CLK_NS;

  // Pin commands
  typedef enum logic [1:0] {
    OP_IN = 2'b00,
    OP_OUT = 2'b01,
    OP_HIGH = 2'b10,
    OP_LOW = 2'b11
  } gpc_op_e;

  // Byte port request
  typedef struct packed {
    logic [2:0] code;
    logic wr;
    logic [9:0] data;
  } gpc_bcmd_s;
endpackage : gpc_pkg

// ===== rtl/gpc_byte_port.sv
`timescale 1ns/1ps
`default_nettype none
module gpc_byte_port (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Sync reset
  input wire logic ce_i, // Clock enable
  input wire logic start_i, // Start request
  input wire gpc_pkg::gpc_bcmd_s cmd_i, // Request fields
  output logic busy_o, // Strobed transfer running
  output logic [9:0] rdata_o, // Captured lines
  input wire logic [7:0] d_i, // Data lines in
  output logic [7:0] d_o, // Data lines out
  output logic [7:0] d_oe_o, // Data drive enables
  input wire logic [1:0] c_i, // Control lines in
  output logic [1:0] c_o, // Control lines out
  output logic [1:0] c_oe_o // Control drive enables
);
  typedef enum logic [1:0] {
    BP_IDLE = 2'b00,
    BP_SETUP = 2'b01,
    BP_STB = 2'b10,
    BP_GAP = 2'b11
  } gpc_bp_e;

  gpc_bp_e st_reg;
  logic [7:0] cnt_reg;
  logic wr_reg;
  logic pol_reg;

  // Decode; codes 5 to 7 are ignored
  wire logic go = start_i && (st_reg == BP_IDLE);
  wire logic go_stb = go && !cmd_i.code[2];
  wire logic go_blk = go && (cmd_i.code == gpc_pkg::CODE_BLOCK);
  wire logic [7:0] stb_len = wr_reg ? 8'(gpc_pkg::WR_STB_CYC)
                                    : 8'(gpc_pkg::RD_STB_CYC);
  // Idle two counts early so start to start equals the period
  wire logic [7:0] gap_end = wr_reg ? 8'(gpc_pkg::WR_GAP_CYC - 2)
                                    : 8'(gpc_pkg::RD_GAP_CYC - 2);
  assign busy_o = st_reg != BP_IDLE;

  // Sequencer: setup, strobe, spacing gap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= BP_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      pol_reg <= 1'b0;
      d_o <= 8'h00;
      d_oe_o <= 8'h00; // R16
      c_o <= 2'h0;
      c_oe_o <= 2'h0; // R16
      rdata_o <= 10'h000;
    end else if (ce_i) begin
      cnt_reg <= cnt_reg + 8'h01;
      unique case (st_reg)
        BP_IDLE: begin
          if (go_stb) begin
            st_reg <= BP_SETUP;
            cnt_reg <= 8'h00;
            wr_reg <= cmd_i.wr;
            pol_reg <= cmd_i.code[1];
            c_o <= {~cmd_i.code[1], cmd_i.code[0]}; // R11 R12
            c_oe_o <= 2'h3;
            d_o <= cmd_i.data[7:0]; // R17
            d_oe_o <= {8{cmd_i.wr}};
          end else if (go_blk) begin
            d_o <= cmd_i.data[7:0]; // R13
            c_o <= cmd_i.data[9:8];
            d_oe_o <= {8{cmd_i.wr}};
            c_oe_o <= {2{cmd_i.wr}};
            if (!cmd_i.wr) rdata_o <= {c_i, d_i};
          end
        end
        BP_SETUP: begin
          st_reg <= BP_STB;
          c_o[1] <= pol_reg; // R12
        end
        BP_STB: begin
          if (cnt_reg == stb_len) begin // R14
            st_reg <= BP_GAP;
            c_o[1] <= ~pol_reg;
            d_oe_o <= 8'h00;
            // Sampled in the last strobe cycle
            if (!wr_reg) rdata_o <= {2'h0, d_i}; // R18
          end
        end
        BP_GAP: begin
          if (cnt_reg == gap_end) st_reg <= BP_IDLE; // R15
        end
      endcase
    end
  end

  // Helper: strobe length and start spacing
  logic [7:0] stb_cnt;
  logic [7:0] since_reg;
  logic [7:0] per_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stb_cnt <= 8'h00;
      since_reg <= 8'hFF;
      per_reg <= 8'h00;
    end else if (ce_i) begin
      stb_cnt <= (st_reg == BP_STB) ? stb_cnt + 8'h01 : 8'h00;
      if (go_stb) since_reg <= 8'h01;
      else if (since_reg != 8'hFF) since_reg <= since_reg + 8'h01;
      if (go_stb) begin
        per_reg <= cmd_i.wr ? 8'(gpc_pkg::WR_GAP_CYC)
                            : 8'(gpc_pkg::RD_GAP_CYC);
      end
    end
  end

  property p_stb_len;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    $fell(st_reg == BP_STB) |-> stb_cnt ==
      (wr_reg ? 8'(gpc_pkg::WR_STB_CYC) : 8'(gpc_pkg::RD_STB_CYC));
  endproperty
  a_stb_len: assert property (p_stb_len) // R14
    else $error("strobe length wrong");

  property p_spacing;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    go_stb |-> since_reg >= per_reg;
  endproperty
  a_spacing: assert property (p_spacing) // R15
    else $error("strobed transfers too close");

  property p_wr_hold;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    (st_reg == BP_STB) && wr_reg |->
      d_oe_o == 8'hFF && $stable(d_o) && $stable(c_o[0]);
  endproperty
  a_wr_hold: assert property (p_wr_hold) // R17
    else $error("write data not held over strobe");

  property p_undriven;
    @(posedge clk_i) disable iff (!ce_i)
    $past(rst_i) |-> d_oe_o == 8'h00 && c_oe_o == 2'h0;
  endproperty
  a_undriven: assert property (p_undriven) // R16
    else $error("byte port driven after reset");

  property p_block;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    go_blk && cmd_i.wr |=> d_oe_o == 8'hFF && c_oe_o == 2'h3 && !busy_o;
  endproperty
  a_block: assert property (p_block) // R13
    else $error("block write not driven");
endmodule : gpc_byte_port
`default_nettype wire

// ===== sim/gpc_periph.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Peripherals on the pins, the byte port and the converter
// ---------------------------------------------------------------
module gpc_periph (
  input wire logic clk_i, // Clock
  input wire logic [23:0] g_i, // Pin levels from block
  input wire logic [23:0] g_oe_i, // Pin enables from block
  output logic [23:0] g_o, // Resolved pin levels
  input wire logic [7:0] d_i, // Data from block
  input wire logic [7:0] d_oe_i, // Data enables
  input wire logic [1:0] c_i, // Control from block
  input wire logic [1:0] c_oe_i, // Control enables
  input wire logic act_i, // Active select level
  input wire logic [7:0] rd_i, // Byte to present
  output logic [7:0] d_o, // Resolved data lines
  output logic [1:0] c_o, // Resolved control lines
  input wire logic start_i, // Conversion start
  input wire logic [9:0] dly_i, // Conversion delay
  input wire logic [9:0] val_i, // Conversion value
  output logic done_o, // Conversion done
  output logic [9:0] res_o // Conversion value out
);
  logic tgl = 1'h0;
  logic busy = 1'h0;
  logic [9:0] cnt = 10'h000;
  wire logic show_w;
  // Answer only while the bus is free and selected or left open
  assign show_w = ~|d_oe_i && (c_oe_i == 2'h0 ||
    (c_oe_i[1] && c_i[1] == act_i));
  // Released lines wander, so a stale value never passes
  assign g_o = (g_oe_i & g_i) | (~g_oe_i & {24{tgl}});
  assign d_o = |d_oe_i ? d_i : show_w ? rd_i : {8{tgl}} ^ 8'h5A;
  assign c_o = (c_oe_i & c_i) | (~c_oe_i & {2{tgl}});
  assign done_o = busy && cnt == dly_i;
  assign res_o = done_o ? val_i : ~val_i;
  // Converter delay counter, slow when dly_i is large
  always @(posedge clk_i) begin
    tgl <= ~tgl;
    cnt <= cnt + 10'h001;
    if (start_i) begin
      busy <= 1'h1;
      cnt <= 10'h000;
    end else if (done_o) begin
      busy <= 1'h0;
    end
  end
endmodule : gpc_periph
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic ack_o, adc_start_o, adc_done_i, act = 1'h0;
  logic [23:0] gpio_i, gpio_o, gpio_oe_o, pad_ana_o;
  logic [2:0] adc_chan_o;
  logic [9:0] adc_data_i, dly = 10'h010, aval = 10'h000;
  logic [7:0] bp_d_i, bp_d_o, bp_d_oe_o, rd_val = 8'h00;
  logic [1:0] bp_c_i, bp_c_o, bp_c_oe_o;
  logic [31:0] rng = 32'h00008815; // Seed 34837
  logic [63:0] note_q[$];
  logic [63:0] note;
  int n_mismatch = 0, checks_done = 0, cyc_n = 0, t_prev = -1000, pw = 0;
  gpc_top i_gpc_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o),
    .pad_ana_o(pad_ana_o), .adc_start_o(adc_start_o),
    .adc_chan_o(adc_chan_o), .adc_done_i(adc_done_i),
    .adc_data_i(adc_data_i), .bp_d_i(bp_d_i), .bp_d_o(bp_d_o),
    .bp_d_oe_o(bp_d_oe_o), .bp_c_i(bp_c_i), .bp_c_o(bp_c_o),
    .bp_c_oe_o(bp_c_oe_o));
  gpc_periph i_gpc_periph (.clk_i(clk_i), .g_i(gpio_o),
    .g_oe_i(gpio_oe_o), .g_o(gpio_i), .d_i(bp_d_o), .d_oe_i(bp_d_oe_o),
    .c_i(bp_c_o), .c_oe_i(bp_c_oe_o), .act_i(act), .rd_i(rd_val),
    .d_o(bp_d_i), .c_o(bp_c_i), .start_i(adc_start_o), .dly_i(dly),
    .val_i(aval), .done_o(adc_done_i), .res_o(adc_data_i));
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_n <= cyc_n + 1;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // ---------------------------------------------------------------
  // Bus master: hold everything until ack is sampled
  // ---------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
      input logic [31:0] d, input logic [31:0] m, input logic [31:0] e);
    int n;
    @(posedge clk_i);
    if (!w) note_q.push_back({m, e});
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'h1 && n < 50);
    if (n >= 50) chk("ack", 1, 0);
    rd = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [3:0] s,
      input logic [31:0] d);
    wb(1'h1, a, s, d, 32'h0, 32'h0);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    wb(1'h0, a, 4'hF, 32'h0, m, e);
  endtask : rc
  // Polls bit 0 of a status word, bounded
  task automatic poll(input logic [7:0] a);
    int n;
    n = 0;
    do begin
      rc(a, 32'h0, 32'h0);
      n++;
    end while (rd[0] !== 1'h0 && n < 200);
  endtask : poll
  // Read answers are matched against the oldest note
  always @(posedge clk_i) begin
    if (ack_o === 1'h1 && we_i === 1'h0) begin
      note = note_q.pop_front();
      if (note[63:32] != 0) chk("dat_o", note[31:0], dat_o & note[63:32]);
    end
  end
  // ---------------------------------------------------------------
  // One strobed transfer, timed on the control lines
  // ---------------------------------------------------------------
  task automatic xfer(input logic [1:0] code, input logic w);
    logic [7:0] v;
    int n;
    rng = xs(rng);
    v = rng[7:0];
    rd_val <= rng[15:8];
    act <= code[1];
    wr(gpc_pkg::OFS_BCMD, 4'h7, {11'h000, w, 2'h0, code, 8'h00, v});
    n = 0;
    while (bp_c_o[1] !== code[1] && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    chk("gap", 1, cyc_n - t_prev >= (pw ? 120 : 100));
    t_prev = cyc_n;
    pw = w;
    chk("ctl", {2'h3, code[0]}, {bp_c_oe_o, bp_c_o[0]});
    chk("dat", w ? {8'hFF, v} : 16'h0, {bp_d_oe_o, w ? bp_d_o : 8'h0});
    n = 0;
    while (bp_c_o[1] === code[1] && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    chk("strobe", w ? 13 : 28, n);
    if (!w) rc(gpc_pkg::OFS_BDAT, 32'hFF, {24'h0, rd_val});
    poll(gpc_pkg::OFS_BCMD);
  endtask : xfer
  // Conversion, slow when the converter never answers in time
  task automatic conv(input logic [9:0] d, input logic [31:0] m);
    int t;
    rng = xs(rng);
    aval <= rng[9:0];
    dly <= d;
    t = cyc_n;
    wr(gpc_pkg::OFS_ADC, 4'h1, 32'h5);
    chk("chan", 4'hD, {adc_start_o, adc_chan_o});
    poll(gpc_pkg::OFS_ADC);
    chk("conv time", 1, cyc_n - t <= 307);
    rc(gpc_pkg::OFS_RES, m, {16'h0, aval, 6'h0} & m);
  endtask : conv
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  // Hang guard, about thirty times the expected run
  initial begin
    #800000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    chk("bp oe", 10'h0, {bp_c_oe_o, bp_d_oe_o});
    chk("ana pins", 24'hFF0000, pad_ana_o);
    rc(gpc_pkg::OFS_DIR, 32'hFFFFFFFF, 32'h0);
    rc(gpc_pkg::OFS_ANA, 32'hFFFFFFFF, 32'hFF);
    rc(8'h3C, 32'hFFFFFFFF, 32'h0);
    // Level must lead direction on a shared pin
    wr(gpc_pkg::OFS_CMD, 4'h3, {22'h0, 2'h2, 3'h0, 5'h14});
    chk("level first", 2'h1, {gpio_oe_o[20], gpio_o[20]});
    @(posedge clk_i);
    chk("then out", 2'h3, {gpio_oe_o[20], gpio_o[20]});
    rng = xs(rng);
    wr(gpc_pkg::OFS_DIR, 4'h3, {16'h0, rng[15:0]});
    rc(gpc_pkg::OFS_DIR, 32'hFFFFFF, {8'h0, 8'h10, rng[15:0]});
    chk("oe", {8'h10, rng[15:0]}, gpio_oe_o);
    wr(gpc_pkg::OFS_OUT, 4'h3, {16'h0, rng[31:16]});
    rc(gpc_pkg::OFS_IN, {16'h0, rng[15:0]},
      {16'h0, rng[31:16] & rng[15:0]});
    rc(gpc_pkg::OFS_ANA, 32'hFF, 32'hEF);
    wr(gpc_pkg::OFS_DIR, 4'h4, 32'h0);
    rc(gpc_pkg::OFS_ANA, 32'hFF, 32'h0);
    conv(10'h020, 32'hFFFF);
    conv(10'h3E8, 32'h3F);
    for (int i = 0; i < 8; i++) xfer(i[1:0], i[2]);
    rng = xs(rng);
    wr(gpc_pkg::OFS_BCMD, 4'h7, {11'h0, 5'h14, 6'h0, rng[9:0]});
    chk("blk", {10'h3FF, rng[9:0]}, {bp_c_oe_o, bp_d_oe_o, bp_c_o, bp_d_o});
    rd_val <= rng[17:10];
    wr(gpc_pkg::OFS_BCMD, 4'h7, 32'h40000);
    wr(gpc_pkg::OFS_BCMD, 4'h7, 32'h40000);
    chk("blk off", 10'h0, {bp_c_oe_o, bp_d_oe_o});
    rc(gpc_pkg::OFS_BDAT, 32'hFF, {24'h0, rd_val});
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    rc(gpc_pkg::OFS_ANA, 32'hFF, 32'hFF);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
